// ===== verilog/lcc_regs.sv
// APB register bank holding the three LED channel current codes.
//
// Notes on behaviour
// - Channel 1 bits 9:8 in 0x03 low bits.
// - Channel 1 bits 7:0 fill register 0x04.
// - Channel 2 bits 9:8 in 0x05 low bits.
// - Channel 2 bits 7:0 fill register 0x06.
// - Channel 3 bits 9:8 in 0x07 low bits.
// - Channel 3 bits 7:0 fill 0x08, reset zero.
// - Full code range zero to 0x3ff accepted.
// - Current is linear in code, zero at zero.
`timescale 1ns/1ps
module lcc_regs (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire lcc_pkg::lcc_apb_req_t apb_req_i,
  output lcc_pkg::lcc_apb_rsp_t      apb_rsp_o,
  output lcc_pkg::lcc_dac_t          dac_o
);

  localparam int REG_W  = lcc_pkg::REG_W;
  localparam int IDX_W  = lcc_pkg::IDX_W;
  localparam int NUM_CH = lcc_pkg::NUM_CH;

  // Word aligned and inside the decoded window; anything else is an error.
  function automatic logic addr_word_ok(input logic [lcc_pkg::ADDR_W-1:0] addr);
    addr_word_ok = (addr[1:0] == 2'b00) && (addr[lcc_pkg::ADDR_W-1:IDX_W+2] == '0);
  endfunction

  function automatic logic idx_is_code(input logic [IDX_W-1:0] idx);
    idx_is_code = (idx >= lcc_pkg::IDX_FIRST) && (idx <= lcc_pkg::IDX_LAST);
  endfunction

  logic [REG_W-1:0]      code_reg [lcc_pkg::NUM_REG];
  logic [REG_W-1:0]      code_next [lcc_pkg::NUM_REG];
  logic [31:0]           prdata_reg;
  logic [31:0]           prdata_next;
  logic                  pslverr_reg;
  logic                  pslverr_next;

  wire                   setup_phase;
  wire                   access_phase;
  wire [IDX_W-1:0]       req_idx;
  wire                   word_ok;
  wire                   hit_code;
  wire                   hit_status;
  wire                   hit_any;
  wire [IDX_W-1:0]       slot_idx;
  wire                   wr_fire;
  wire [REG_W-1:0]       rd_code_byte;
  wire [REG_W-1:0]       status_byte;

  wire [NUM_CH-1:0][lcc_pkg::CODE_W-1:0] ch_code;
  wire [NUM_CH-1:0][lcc_pkg::CUR_W-1:0]  ch_current;
  wire [NUM_CH-1:0]                      ch_active;

  assign setup_phase  = apb_req_i.psel & ~apb_req_i.penable;
  assign access_phase = apb_req_i.psel & apb_req_i.penable;
  assign req_idx      = apb_req_i.paddr[IDX_W+1:2];
  assign word_ok      = addr_word_ok(apb_req_i.paddr);
  assign hit_code     = word_ok & idx_is_code(req_idx);
  assign hit_status   = word_ok & (req_idx == lcc_pkg::IDX_STATUS);
  assign hit_any      = hit_code | hit_status;
  assign slot_idx     = req_idx - lcc_pkg::IDX_FIRST;

  // Zero wait states: the write lands at the access edge, where pready is high.
  assign wr_fire = access_phase & apb_req_i.pwrite & hit_code & apb_req_i.pstrb[0];

  // Only byte lane 0 carries register data; the upper lanes are ignored.
  generate
    for (genvar r = 0; r < lcc_pkg::NUM_REG; r++) begin : g_reg
      assign code_next[r] = (wr_fire && (slot_idx == IDX_W'(r))) ? apb_req_i.pwdata[REG_W-1:0] : code_reg[r];

      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          code_reg[r] <= lcc_pkg::CODE_REG_RESET;
        end else begin
          code_reg[r] <= code_next[r];
        end
      end
    end
  endgenerate

  // Channel c uses slot 2c as its high half and slot 2c+1 as its low half.
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      lcc_channel_code u_ch (
        .ref_clk_i    (ref_clk_i),
        .rst_n_i      (rst_n_i),
        .high_reg_i   (code_reg[2*c]),
        .low_reg_i    (code_reg[2*c+1]),
        .code_o       (ch_code[c]),
        .current_ua_o (ch_current[c]),
        .active_o     (ch_active[c])
      );
    end
  endgenerate

  // Upper six bits of a high register are stored and read back but never reach the code.
  assign rd_code_byte = hit_code ? code_reg[slot_idx[2:0]] : '0;
  assign status_byte  = {{(REG_W-NUM_CH){1'b0}}, ch_active};

  // Read data is captured in the setup cycle so it leaves a flip-flop in the access cycle.
  assign prdata_next  = setup_phase ? {24'h000000, (hit_status ? status_byte : rd_code_byte)} : prdata_reg;
  assign pslverr_next = setup_phase ? ~hit_any : pslverr_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign apb_rsp_o.prdata  = prdata_reg;
  assign apb_rsp_o.pready  = 1'b1;
  assign apb_rsp_o.pslverr = access_phase & pslverr_reg;

  assign dac_o.code       = ch_code;
  assign dac_o.current_ua = ch_current;
  assign dac_o.active     = ch_active;

endmodule

// ===== verilog/lcc_pkg.sv
// Package with the register map, field layout and carrier types of the LED channel current code block.
package lcc_pkg;

  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int REG_W   = 8;
  localparam int CODE_W  = 10;
  localparam int NUM_CH  = 3;
  localparam int NUM_REG = 2 * NUM_CH;
  localparam int IDX_W   = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CH1_HIGH = 8'h03;
  localparam logic [IDX_W-1:0] IDX_CH1_LOW  = 8'h04;
  localparam logic [IDX_W-1:0] IDX_CH2_HIGH = 8'h05;
  localparam logic [IDX_W-1:0] IDX_CH2_LOW  = 8'h06;
  localparam logic [IDX_W-1:0] IDX_CH3_HIGH = 8'h07;
  localparam logic [IDX_W-1:0] IDX_CH3_LOW  = 8'h08;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 8'h0c;
  localparam logic [IDX_W-1:0] IDX_FIRST    = IDX_CH1_HIGH;
  localparam logic [IDX_W-1:0] IDX_LAST     = IDX_CH3_LOW;

  localparam logic [REG_W-1:0] CODE_REG_RESET = 8'h00;

  // High register keeps code bits 9:8 in its two least significant bits.
  localparam int HIGH_CODE_LSB = 0;
  localparam int HIGH_CODE_MSB = 1;
  localparam int HIGH_CODE_W   = HIGH_CODE_MSB - HIGH_CODE_LSB + 1;

  localparam logic [CODE_W-1:0] CODE_MAX = 10'h3ff;

  // Nominal current step in microamps and the width of the estimate it feeds.
  localparam int STEP_UA = 2470;
  localparam int CUR_W   = 22;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
  } lcc_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } lcc_apb_rsp_t;

  typedef struct packed {
    logic [NUM_CH-1:0][CODE_W-1:0] code;
    logic [NUM_CH-1:0][CUR_W-1:0]  current_ua;
    logic [NUM_CH-1:0]             active;
  } lcc_dac_t;

endpackage

// ===== verilog/lcc_channel_code.sv
// One channel: joins the high and low register halves into the applied current code.
`timescale 1ns/1ps
module lcc_channel_code (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic [lcc_pkg::REG_W-1:0]  high_reg_i,
  input  wire logic [lcc_pkg::REG_W-1:0]  low_reg_i,
  output logic      [lcc_pkg::CODE_W-1:0] code_o,
  output logic      [lcc_pkg::CUR_W-1:0]  current_ua_o,
  output logic                            active_o
);

  logic [lcc_pkg::CODE_W-1:0] code_next;
  logic [lcc_pkg::CUR_W-1:0]  current_next;
  logic                       active_next;

  // Every value up to the full scale code passes unclamped.
  assign code_next = {high_reg_i[lcc_pkg::HIGH_CODE_MSB:lcc_pkg::HIGH_CODE_LSB], low_reg_i};

  // Estimate is linear with a zero intercept, so code zero means no current.
  assign current_next = lcc_pkg::CUR_W'(code_next) * lcc_pkg::CUR_W'(lcc_pkg::STEP_UA);
  assign active_next  = (code_next != '0);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_o       <= '0;
      current_ua_o <= '0;
      active_o     <= 1'b0;
    end else begin
      code_o       <= code_next;
      current_ua_o <= current_next;
      active_o     <= active_next;
    end
  end

endmodule

// ===== testbench/lcc_regs_asserts.sv
// Checker with port-level assertions for the LED channel current code register bank.
`timescale 1ns/1ps
module lcc_regs_asserts (
  input wire logic                  ref_clk_i,
  input wire logic                  rst_n_i,
  input wire lcc_pkg::lcc_apb_req_t apb_req_i,
  input wire lcc_pkg::lcc_apb_rsp_t apb_rsp_o,
  input wire lcc_pkg::lcc_dac_t     dac_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // The code shows a write two edges later: register first, then the channel flop.
  wire logic        wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & apb_req_i.pstrb[0];
  wire logic [11:0] a  = apb_req_i.paddr;
  wire logic [7:0]  d  = apb_req_i.pwdata[7:0];
  a_ch1_high: assert property (wr && a == 12'h00c |=> ##1 dac_o.code[0][9:8] == $past(d[1:0], 2))
    else $error("ch1 high bits wrong");
  a_ch1_low: assert property (wr && a == 12'h010 |=> ##1 dac_o.code[0][7:0] == $past(d, 2))
    else $error("ch1 low byte wrong");
  a_ch2_high: assert property (wr && a == 12'h014 |=> ##1 dac_o.code[1][9:8] == $past(d[1:0], 2))
    else $error("ch2 high bits wrong");
  a_ch2_low: assert property (wr && a == 12'h018 |=> ##1 dac_o.code[1][7:0] == $past(d, 2))
    else $error("ch2 low byte wrong");
  a_ch3_high: assert property (wr && a == 12'h01c |=> ##1 dac_o.code[2][9:8] == $past(d[1:0], 2))
    else $error("ch3 high bits wrong");
  a_ch3_low: assert property (wr && a == 12'h020 |=> ##1 dac_o.code[2][7:0] == $past(d, 2))
    else $error("ch3 low byte wrong");
  a_low_keeps_high: assert property (wr && a == 12'h010 |=> ##1 dac_o.code[0][9:8] == $past(dac_o.code[0][9:8], 2))
    else $error("high bits lost");
  a_current_step: assert property (dac_o.current_ua[0] == dac_o.code[0] * 2470 && dac_o.active[0] == (dac_o.code[0] != 0))
    else $error("current not linear");
endmodule
bind lcc_regs lcc_regs_asserts u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .dac_o(dac_o));

// ===== testbench/lcc_regs_tb.sv
// Self-checking testbench for the LED channel current code register bank.
`timescale 1ns/1ps
module lcc_regs_tb;
  logic                  clk;
  logic                  rst_n;
  lcc_pkg::lcc_apb_req_t req;
  lcc_pkg::lcc_apb_rsp_t rsp;
  lcc_pkg::lcc_dac_t     dac;
  logic [31:0]           rd;
  logic                  er;
  logic [9:0]            cd [3];
  int                    n_fail;
  int                    n_tests;
  lcc_regs dut (.ref_clk_i(clk), .rst_n_i(rst_n), .apb_req_i(req), .apb_rsp_o(rsp), .dac_o(dac));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}, pstrb: 4'h1};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    n_fail = 0;
    n_tests = 0;
    cd = '{10'h3ff, 10'h029, 10'h200};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int r = 3; r <= 8; r++) begin
      xfer(12'(r * 4), 1'b0, 8'h00);
      chk("reset value", rd, 32'h0);
      chk("reset error", 32'(er), 32'h0);
    end
    // A pattern in the upper six bits proves they stay out of the code.
    for (int c = 0; c < 3; c++) begin
      xfer(12'(12 + 8 * c), 1'b1, {6'h2a, cd[c][9:8]});
      xfer(12'(16 + 8 * c), 1'b1, cd[c][7:0]);
    end
    @(negedge clk);
    for (int c = 0; c < 3; c++) begin
      chk("code", 32'(dac.code[c]), 32'(cd[c]));
      chk("current", 32'(dac.current_ua[c]), 32'(cd[c]) * 2470);
      chk("active", 32'(dac.active[c]), 32'(cd[c] != 0));
    end
    @(posedge clk);
    for (int c = 0; c < 3; c++) begin
      xfer(12'(12 + 8 * c), 1'b0, 8'h00);
      chk("high reg", rd, {24'h0, 6'h2a, cd[c][9:8]});
      xfer(12'(16 + 8 * c), 1'b0, 8'h00);
      chk("low reg", rd, {24'h0, cd[c][7:0]});
    end
    xfer(12'h030, 1'b0, 8'h00);
    chk("status all active", rd, 32'h7);
    xfer(12'h010, 1'b1, 8'h00);
    @(negedge clk);
    chk("ch1 code", 32'(dac.code[0]), 32'h300);
    @(posedge clk);
    xfer(12'h00c, 1'b1, 8'h00);
    @(negedge clk);
    chk("ch1 current", 32'(dac.current_ua[0]), 32'h0);
    @(posedge clk);
    xfer(12'h030, 1'b0, 8'h00);
    chk("status ch1 idle", rd, 32'h6);
    xfer(12'h024, 1'b0, 8'h00);
    chk("unmapped error", 32'(er), 32'h1);
    chk("unmapped data", rd, 32'h0);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("ch3 code after reset", 32'(dac.code[2]), 32'h0);
    tally_and_finish;
  end
endmodule
